// ---- msc_pkg.sv ----
package msc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  // Minimum reset pulse in nanoseconds; a longer low starts a module reset.
  localparam int unsigned RESET_MIN_NS = 10_000;
  // Least time rounds up to whole cycles.
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RST_CNT_W = 8;
  localparam logic [RST_CNT_W-1:0] RESET_FILT_CNT = RST_CNT_W'(RESET_MIN_CYC);
  localparam int unsigned LANES = 4;
  localparam int unsigned FLAG_FIRST = 3;
  localparam int unsigned FLAG_LAST = 21;
  localparam int unsigned FLAG_BYTES = FLAG_LAST - FLAG_FIRST + 1;
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [7:0] STATUS_BYTE = 8'h02;
  localparam int unsigned NOT_READY_BIT = 0;
  localparam logic [7:0] POWER_CTRL_BYTE = 8'h5d;
  localparam int unsigned PWR_OVERRIDE_BIT = 0;
  localparam int unsigned PWR_SET_BIT = 1;
  localparam int unsigned HIGH_CLASS_BIT = 2;
  localparam logic [2:0] POWER_CTRL_RESET = 3'h0;
  localparam logic IN_MODE_RESET = 1'b0;
  localparam logic OUT_MODE_RESET = 1'b0;
  typedef enum logic [1:0] {MSC_RUN, MSC_IN_RESET} msc_state_t;
endpackage : msc_pkg

// ---- msc_sync_if.sv ----
`timescale 1ns/100ps
interface msc_sync_if;
  logic select_n;
  logic reset_n;
  logic dual_in;
  modport src (output select_n, output reset_n, output dual_in);
  modport dst (input select_n, input reset_n, input dual_in);
endinterface : msc_sync_if

// ---- msc_sync.sv ----
`timescale 1ns/100ps
module msc_sync
  import msc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic module_select_n_i,
  input wire logic module_reset_n_i,
  input wire logic power_or_txoff_pin_i,
  msc_sync_if.src sync
);
  logic [2:0] stage1_reg;
  logic [2:0] stage2_reg;

  // Idle levels are the pulled-up levels, so nothing spurious happens at release.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1_reg <= 3'h7;
      stage2_reg <= 3'h7;
    end else begin
      stage1_reg <= {power_or_txoff_pin_i, module_reset_n_i, module_select_n_i}; // R23
      stage2_reg <= stage1_reg; // R23
    end
  end

  assign sync.select_n = stage2_reg[0];
  assign sync.reset_n = stage2_reg[1];
  assign sync.dual_in = stage2_reg[2];
endmodule : msc_sync

// ---- msc_sideband.sv ----
`timescale 1ns/100ps
// Function
// R01: Select low lets the module answer and acknowledge management bus traffic.
// R02: Select high means no answer and no acknowledge on the bus.
// R03: Host waits settling times around select changes before bus traffic.
// R04: Reset input low longer than 10 us resets every user setting.
// R05: Dual input is active high and means low power request after reset.
// R06: Input may become transmit-off by software, except while reset runs.
// R07: Low power mode: transmit-off inactive; power from pin plus byte 93 bits 0-2.
// R08: Transmit-off mode: low power inactive; pin 1 disables, 0 enables transmitters.
// R09: Switch to transmit-off with pin high disables transmitters, leaves low power.
// R10: Switch with pin low changes meaning only; power follows override bits.
// R11: Presence output is held low while the module is inserted.
// R12: Dual output is active-low open-collector, interrupt after reset.
// R13: Output may become receive-loss by software, except while reset runs.
// R14: Interrupt mode drives low on fault or any unmasked flag.
// R15: After reset, with not-ready clear, reading that bit releases interrupt.
// R16: Other causes release only after their flag is read; the fault cause follows fault_i and releases the pin as soon as it drops.
// R17: Receive-loss mode drives low while any lane has loss.
// R18: Transmitters stay disabled while held in reset.
// R19: Receiver outputs squelch whenever receive loss is indicated; squelch here follows lane loss only in receive-loss mode.
// R20: Flag bytes 3 to 21 are read-only and clear on read.
// R21: Bus address is 1010000 with the last bit giving direction.
// R22: Reset pulses shorter than the minimum are filtered out.
// R23: Select, reset and dual input are synchronised before use.
module msc_sideband
  import msc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic module_select_n_i,
  input wire logic module_reset_n_i,
  input wire logic power_or_txoff_pin_i,
  input wire logic [6:0] bus_addr_i,
  input wire logic bus_start_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic set_in_mode_i,
  input wire logic set_out_mode_i,
  input wire logic [FLAG_BYTES-1:0] flag_event_i,
  input wire logic [FLAG_BYTES-1:0] flag_mask_i,
  input wire logic fault_i,
  input wire logic data_not_ready_i,
  input wire logic [LANES-1:0] lane_los_i,
  output logic bus_ack_o,
  output logic [FLAG_BYTES-1:0] flags_o,
  output logic [2:0] power_ctrl_o,
  output logic in_mode_txoff_o,
  output logic out_mode_los_o,
  output logic low_power_o,
  output logic tx_disable_o,
  output logic rx_squelch_o,
  output logic module_in_reset_o,
  output logic presence_n_o,
  output logic presence_n_oe_o,
  output logic irq_or_los_pin_o,
  output logic irq_or_los_pin_oe_o
);
  msc_sync_if sync ();
  msc_state_t state_reg;
  msc_state_t state_next;
  logic [RST_CNT_W-1:0] low_cnt_reg;
  logic in_mode_reg;
  logic out_mode_reg;
  logic [2:0] power_ctrl_reg;
  logic [FLAG_BYTES-1:0] flag_reg;
  logic reset_irq_reg;
  logic bus_ack_reg;
  logic module_in_reset_reg;
  logic presence_n_reg;
  logic presence_oe_reg;
  logic irq_pin_level_reg;
  logic low_power_reg;
  logic tx_disable_reg;
  logic rx_squelch_reg;
  logic pin_low_reg;
  logic in_reset;
  logic in_lp;
  logic in_txoff;
  logic lp_next;
  logic txd_next;
  logic any_los;
  logic irq_active;
  logic rd_status;
  logic bus_selected;
  logic addr_match;
  logic power_wr;
  logic fault_cause;
  logic flag_cause;
  logic reset_cause;
  logic pin_low_next;
  wire logic [FLAG_BYTES-1:0] flag_rd_hit;

  msc_sync u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .module_select_n_i(module_select_n_i),
    .module_reset_n_i(module_reset_n_i),
    .power_or_txoff_pin_i(power_or_txoff_pin_i),
    .sync(sync)
  );

  assign in_reset = (state_reg == MSC_IN_RESET);

  // Low time of the reset input; it saturates so a long hold stays in reset.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_cnt_reg <= '0;
    end else if (sync.reset_n) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != RESET_FILT_CNT) begin
      low_cnt_reg <= low_cnt_reg + RST_CNT_W'(1); // R22
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MSC_RUN: begin
        if (!sync.reset_n && low_cnt_reg == RESET_FILT_CNT) begin
          state_next = MSC_IN_RESET; // R04 R22
        end
      end
      MSC_IN_RESET: begin
        if (sync.reset_n) begin
          state_next = MSC_RUN;
        end
      end
      default: state_next = MSC_IN_RESET;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= MSC_IN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // A registered copy keeps the status output free of decode glitches.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      module_in_reset_reg <= 1'b1;
    end else begin
      module_in_reset_reg <= (state_next == MSC_IN_RESET); // R04
    end
  end

  // Mode selections are refused while a reset runs and return to defaults.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_mode_reg <= IN_MODE_RESET;
    end else if (in_reset) begin
      in_mode_reg <= IN_MODE_RESET; // R05
    end else if (set_in_mode_i) begin
      in_mode_reg <= 1'b1; // R06
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_mode_reg <= OUT_MODE_RESET;
    end else if (in_reset) begin
      out_mode_reg <= OUT_MODE_RESET; // R12
    end else if (set_out_mode_i) begin
      out_mode_reg <= 1'b1; // R13
    end
  end

  // A write to any other byte is left to the bus engine's own memory.
  assign power_wr = reg_wr_i && reg_addr_i == POWER_CTRL_BYTE; // R07

  // Power control byte written over the management bus.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_ctrl_reg <= POWER_CTRL_RESET;
    end else if (in_reset) begin
      power_ctrl_reg <= POWER_CTRL_RESET; // R04
    end else if (power_wr) begin
      power_ctrl_reg <= {reg_wdata_i[HIGH_CLASS_BIT], reg_wdata_i[PWR_SET_BIT], reg_wdata_i[PWR_OVERRIDE_BIT]}; // R07
    end
  end

  // Each address phase is judged on the synchronised select level of its own cycle.
  assign bus_selected = !sync.select_n; // R01 R02
  assign addr_match = bus_addr_i == DEV_ADDR; // R21

  // Acknowledge only when selected and addressed; the bit after the address is direction.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_ack_reg <= 1'b0;
    end else begin
      bus_ack_reg <= bus_start_i && bus_selected && addr_match; // R01 R02 R21
    end
  end

  // Flag bytes: set wins over a clear-on-read in the same cycle.
  genvar g;
  generate
    for (g = 0; g < FLAG_BYTES; g++) begin : g_flag
      // Per-byte read strobe for the clear-on-read flags.
      assign flag_rd_hit[g] = reg_rd_i && reg_addr_i == 8'(FLAG_FIRST + g); // R20
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          flag_reg[g] <= 1'b0;
        end else if (in_reset) begin
          flag_reg[g] <= 1'b0;
        end else if (flag_event_i[g]) begin
          flag_reg[g] <= 1'b1;
        end else if (flag_rd_hit[g]) begin
          flag_reg[g] <= 1'b0; // R20 R16
        end
      end
    end
  endgenerate

  assign rd_status = reg_rd_i && reg_addr_i == STATUS_BYTE;

  // Reset-caused interrupt stands until not-ready is clear and has been read.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reset_irq_reg <= 1'b1;
    end else if (in_reset) begin
      reset_irq_reg <= 1'b1;
    end else if (rd_status && !data_not_ready_i) begin
      reset_irq_reg <= 1'b0; // R15
    end
  end

  assign in_txoff = in_mode_reg;
  assign in_lp = !in_mode_reg;
  assign any_los = |lane_los_i;

  // Causes are kept apart so that each one can be traced to its own release path.
  assign fault_cause = fault_i; // R14
  assign flag_cause = |(flag_reg & ~flag_mask_i); // R14 R16
  // The reset cause waits for the reset to end, so the pin does not flicker while settings clear.
  assign reset_cause = reset_irq_reg && !in_reset; // R15
  assign irq_active = fault_cause || flag_cause || reset_cause; // R14

  // Outside reset, only the transmit-off meaning of the pin may switch the transmitters off.
  always_comb begin
    txd_next = 1'b0; // R07
    if (in_txoff) begin
      // A switch with the pin high disables at once, and with the override bit clear low power is dropped in the same cycle.
      txd_next = sync.dual_in; // R08 R09
    end
    if (in_reset) begin
      txd_next = 1'b1; // R18
    end
  end

  // The override bit hands the decision from the pin to the power-set bit in either mode.
  always_comb begin
    lp_next = 1'b0;
    if (power_ctrl_reg[PWR_OVERRIDE_BIT]) begin
      lp_next = power_ctrl_reg[PWR_SET_BIT]; // R07 R10
    end else if (in_lp) begin
      lp_next = sync.dual_in; // R05 R07
    end
  end

  // Which condition owns the shared pin depends only on the output mode.
  always_comb begin
    if (out_mode_reg) begin
      pin_low_next = any_los; // R17
    end else begin
      pin_low_next = irq_active; // R14 R16
    end
  end

  // Low power comes up set so that nothing draws full power before the pin is known.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_power_reg <= 1'b1;
    end else begin
      low_power_reg <= lp_next;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_disable_reg <= 1'b1;
    end else begin
      tx_disable_reg <= txd_next; // R08 R18
    end
  end

  // Squelch follows the loss meaning of the pin; in interrupt mode the host learns of loss from the flags.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_squelch_reg <= 1'b0;
    end else begin
      rx_squelch_reg <= out_mode_reg && any_los; // R19
    end
  end

  // One register on the pin keeps the open-collector enable free of decode glitches.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_low_reg <= 1'b0;
    end else begin
      pin_low_reg <= pin_low_next; // R14 R17
    end
  end

  // Presence is a static pull to ground whenever the logic is powered.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presence_n_reg <= 1'b0;
      presence_oe_reg <= 1'b1;
    end else begin
      presence_n_reg <= 1'b0; // R11
      presence_oe_reg <= 1'b1; // R11
    end
  end

  // The dual output only ever pulls low, so its level never leaves zero.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_pin_level_reg <= 1'b0;
    end else begin
      irq_pin_level_reg <= 1'b0; // R12
    end
  end

  assign bus_ack_o = bus_ack_reg;
  assign flags_o = flag_reg;
  assign power_ctrl_o = power_ctrl_reg;
  assign in_mode_txoff_o = in_mode_reg;
  assign out_mode_los_o = out_mode_reg;
  assign low_power_o = low_power_reg;
  assign tx_disable_o = tx_disable_reg;
  assign rx_squelch_o = rx_squelch_reg;
  assign module_in_reset_o = module_in_reset_reg;
  assign presence_n_o = presence_n_reg;
  assign presence_n_oe_o = presence_oe_reg;
  assign irq_or_los_pin_o = irq_pin_level_reg; // R12
  assign irq_or_los_pin_oe_o = pin_low_reg; // R12
endmodule : msc_sideband

// ---- msc_sideband_props.sv ----
`timescale 1ns/100ps
module msc_sideband_props
  import msc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic module_select_n_i,
  input wire logic power_or_txoff_pin_i,
  input wire logic [6:0] bus_addr_i,
  input wire logic bus_start_i,
  input wire logic [LANES-1:0] lane_los_i,
  input wire logic bus_ack_o,
  input wire logic [2:0] power_ctrl_o,
  input wire logic in_mode_txoff_o,
  input wire logic out_mode_los_o,
  input wire logic low_power_o,
  input wire logic tx_disable_o,
  input wire logic rx_squelch_o,
  input wire logic module_in_reset_o,
  input wire logic irq_or_los_pin_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Three cycles of a steady pin cover the two-flop synchroniser.
  sequence s_sel_held;
    !module_select_n_i [*3];
  endsequence
  sequence s_desel_held;
    module_select_n_i [*3];
  endsequence
  sequence s_txoff_high;
    (in_mode_txoff_o && power_or_txoff_pin_i && !module_in_reset_o) [*4];
  endsequence
  AST_ACK_GIVEN: assert property (s_sel_held ##0 (bus_start_i && bus_addr_i == DEV_ADDR) |=> bus_ack_o)
    else $error("selected module did not acknowledge");
  AST_ACK_CAUSE: assert property (bus_ack_o |-> $past(bus_start_i))
    else $error("acknowledge without a start");
  AST_ACK_DESEL: assert property (s_desel_held ##0 bus_start_i |=> !bus_ack_o)
    else $error("deselected module acknowledged");
  AST_ACK_ADDR: assert property (bus_start_i && bus_addr_i != DEV_ADDR |=> !bus_ack_o)
    else $error("foreign address acknowledged");
  AST_TXOFF_PIN: assert property (s_txoff_high |=> tx_disable_o)
    else $error("transmitters not disabled by high pin");
  AST_TXOFF_LP: assert property (in_mode_txoff_o && !module_in_reset_o && !power_ctrl_o[0]
    |=> !low_power_o || module_in_reset_o)
    else $error("low power taken in transmit-off mode");
  AST_RESET_TX: assert property (module_in_reset_o && $past(module_in_reset_o) |-> tx_disable_o)
    else $error("transmitters enabled during reset");
  AST_LOS_SET: assert property (out_mode_los_o && !module_in_reset_o && lane_los_i != '0
    |=> irq_or_los_pin_oe_o && rx_squelch_o)
    else $error("lane loss not shown or not squelched");
  AST_LOS_REL: assert property (out_mode_los_o && !module_in_reset_o && lane_los_i == '0
    |=> !irq_or_los_pin_oe_o || module_in_reset_o)
    else $error("loss output held with no lane loss");
endmodule : msc_sideband_props
bind msc_sideband msc_sideband_props props_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .module_select_n_i(module_select_n_i), .power_or_txoff_pin_i(power_or_txoff_pin_i), .bus_addr_i(bus_addr_i),
  .bus_start_i(bus_start_i), .lane_los_i(lane_los_i), .bus_ack_o(bus_ack_o), .power_ctrl_o(power_ctrl_o),
  .in_mode_txoff_o(in_mode_txoff_o), .out_mode_los_o(out_mode_los_o), .low_power_o(low_power_o),
  .tx_disable_o(tx_disable_o), .rx_squelch_o(rx_squelch_o), .module_in_reset_o(module_in_reset_o),
  .irq_or_los_pin_oe_o(irq_or_los_pin_oe_o));

// ---- msc_host.sv ----
`timescale 1ns/100ps
module msc_host (
  input wire logic clk_i,
  input wire logic irq_i,
  input wire logic irq_oe_i,
  output logic select_n_o,
  output logic reset_n_o,
  output logic pin_o,
  output logic irq_line_o
);
  // The board pull-up makes the line read high whenever the module lets go.
  assign irq_line_o = irq_oe_i ? irq_i : 1'b1;
  initial begin
    select_n_o = 1'b1;
    reset_n_o = 1'b1;
    pin_o = 1'b0;
  end
  task automatic pins(input logic s, input logic r, input logic p);
    @(negedge clk_i);
    select_n_o = s;
    reset_n_o = r;
    pin_o = p;
    repeat (4) @(negedge clk_i);
  endtask : pins
endmodule : msc_host

// ---- test_module_sideband_control.sv ----
`timescale 1ns/100ps
module test_module_sideband_control
  import msc_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic module_select_n_i, module_reset_n_i, power_or_txoff_pin_i, irq_line;
  logic [6:0] bus_addr_i = '0;
  logic bus_start_i = 0, reg_wr_i = 0, reg_rd_i = 0, set_in_mode_i = 0, set_out_mode_i = 0;
  logic fault_i = 0, data_not_ready_i = 0;
  logic [7:0] reg_addr_i = '0, reg_wdata_i = '0;
  logic [FLAG_BYTES-1:0] flag_event_i = '0, flag_mask_i = '0, flags_o;
  logic [LANES-1:0] lane_los_i = '0;
  logic [2:0] power_ctrl_o;
  logic bus_ack_o, in_mode_txoff_o, out_mode_los_o, low_power_o, tx_disable_o, rx_squelch_o;
  logic module_in_reset_o, presence_n_o, presence_n_oe_o, irq_or_los_pin_o, irq_or_los_pin_oe_o;
  int n_fail = 0, comparisons = 0;
  always #50 clk_i = ~clk_i;
  msc_host host_u (.clk_i(clk_i), .irq_i(irq_or_los_pin_o), .irq_oe_i(irq_or_los_pin_oe_o),
    .select_n_o(module_select_n_i), .reset_n_o(module_reset_n_i), .pin_o(power_or_txoff_pin_i),
    .irq_line_o(irq_line));
  msc_sideband dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .module_select_n_i(module_select_n_i),
    .module_reset_n_i(module_reset_n_i), .power_or_txoff_pin_i(power_or_txoff_pin_i), .bus_addr_i(bus_addr_i),
    .bus_start_i(bus_start_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .set_in_mode_i(set_in_mode_i), .set_out_mode_i(set_out_mode_i),
    .flag_event_i(flag_event_i), .flag_mask_i(flag_mask_i), .fault_i(fault_i),
    .data_not_ready_i(data_not_ready_i), .lane_los_i(lane_los_i), .bus_ack_o(bus_ack_o), .flags_o(flags_o),
    .power_ctrl_o(power_ctrl_o), .in_mode_txoff_o(in_mode_txoff_o), .out_mode_los_o(out_mode_los_o),
    .low_power_o(low_power_o), .tx_disable_o(tx_disable_o), .rx_squelch_o(rx_squelch_o),
    .module_in_reset_o(module_in_reset_o), .presence_n_o(presence_n_o), .presence_n_oe_o(presence_n_oe_o),
    .irq_or_los_pin_o(irq_or_los_pin_o), .irq_or_los_pin_oe_o(irq_or_los_pin_oe_o));
  task automatic chk(input logic [FLAG_BYTES-1:0] got, input logic [FLAG_BYTES-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic bus(input logic [6:0] a, input logic e);
    @(negedge clk_i);
    bus_addr_i = a;
    bus_start_i = 1'b1;
    @(negedge clk_i);
    bus_start_i = 1'b0;
    chk(bus_ack_o, e);
  endtask : bus
  task automatic reg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_i = w;
    reg_rd_i = !w;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    cyc(3);
  endtask : reg_op
  task automatic strobe(input logic i, input logic o, input logic [FLAG_BYTES-1:0] f);
    @(negedge clk_i);
    set_in_mode_i = i;
    set_out_mode_i = o;
    flag_event_i = f;
    @(negedge clk_i);
    set_in_mode_i = 1'b0;
    set_out_mode_i = 1'b0;
    flag_event_i = '0;
    cyc(3);
  endtask : strobe
  task automatic t_boot;
    chk({in_mode_txoff_o, out_mode_los_o}, 2'b00);
    chk({presence_n_oe_o, presence_n_o, irq_or_los_pin_o}, 3'b100);
    chk(irq_line, 1'b0);
    reg_op(1'b0, STATUS_BYTE, 8'h00);
    chk(irq_line, 1'b1);
    $display("boot done");
  endtask : t_boot
  task automatic t_bus;
    host_u.pins(1'b0, 1'b1, 1'b0);
    bus(DEV_ADDR, 1'b1);
    bus(7'h51, 1'b0);
    bus(DEV_ADDR, 1'b1);
    host_u.pins(1'b1, 1'b1, 1'b0);
    bus(DEV_ADDR, 1'b0);
    $display("bus done");
  endtask : t_bus
  task automatic t_power;
    reg_op(1'b1, POWER_CTRL_BYTE, 8'h07);
    chk(power_ctrl_o, 3'h7);
    chk({low_power_o, tx_disable_o}, 2'b10);
    reg_op(1'b1, POWER_CTRL_BYTE, 8'h01);
    chk(low_power_o, 1'b0);
    reg_op(1'b1, POWER_CTRL_BYTE, 8'h00);
    host_u.pins(1'b1, 1'b1, 1'b1);
    chk({low_power_o, tx_disable_o}, 2'b10);
    $display("power done");
  endtask : t_power
  task automatic t_txoff;
    strobe(1'b1, 1'b0, '0);
    chk({in_mode_txoff_o, low_power_o, tx_disable_o}, 3'b101);
    host_u.pins(1'b1, 1'b1, 1'b0);
    chk(tx_disable_o, 1'b0);
    host_u.pins(1'b1, 1'b1, 1'b1);
    chk({low_power_o, tx_disable_o}, 2'b01);
    $display("txoff done");
  endtask : t_txoff
  task automatic t_irq;
    flag_mask_i = 19'h00002;
    strobe(1'b0, 1'b0, 19'h00002);
    chk(irq_line, 1'b1);
    strobe(1'b0, 1'b0, 19'h00001);
    chk({irq_line, flags_o[0]}, 2'b01);
    reg_op(1'b0, 8'h03, 8'h00);
    chk({irq_line, flags_o[0]}, 2'b10);
    fault_i = 1'b1;
    cyc(3);
    chk(irq_line, 1'b0);
    fault_i = 1'b0;
    cyc(3);
    chk(irq_line, 1'b1);
    $display("irq done");
  endtask : t_irq
  task automatic t_los;
    strobe(1'b0, 1'b1, '0);
    chk(out_mode_los_o, 1'b1);
    lane_los_i = 4'h8;
    cyc(3);
    chk({irq_line, rx_squelch_o}, 2'b01);
    lane_los_i = 4'h0;
    cyc(3);
    chk({irq_line, rx_squelch_o}, 2'b10);
    $display("los done");
  endtask : t_los
  // The short pulse stays well under the filter length so that only a real reset is seen.
  task automatic t_mreset;
    host_u.pins(1'b1, 1'b0, 1'b0);
    cyc(45);
    host_u.pins(1'b1, 1'b1, 1'b0);
    chk({module_in_reset_o, out_mode_los_o}, 2'b01);
    host_u.pins(1'b1, 1'b0, 1'b0);
    cyc(106);
    chk({module_in_reset_o, tx_disable_o}, 2'b11);
    strobe(1'b1, 1'b1, '0);
    host_u.pins(1'b1, 1'b1, 1'b0);
    cyc(4);
    chk({in_mode_txoff_o, out_mode_los_o, module_in_reset_o}, 3'b000);
    chk(power_ctrl_o, 3'h0);
    reg_op(1'b1, POWER_CTRL_BYTE, 8'h03);
    strobe(1'b1, 1'b0, '0);
    chk({low_power_o, tx_disable_o}, 2'b10);
    chk(irq_line, 1'b0);
    data_not_ready_i = 1'b1;
    reg_op(1'b0, STATUS_BYTE, 8'h00);
    chk(irq_line, 1'b0);
    data_not_ready_i = 1'b0;
    reg_op(1'b0, STATUS_BYTE, 8'h00);
    chk(irq_line, 1'b1);
    $display("module reset done");
  endtask : t_mreset
  task automatic wrap_up;
    $display("comparisons %0d, failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(negedge clk_i);
    reset_n_i = 1'b1;
    cyc(8);
    t_boot;
    t_bus;
    t_power;
    t_txoff;
    t_irq;
    t_los;
    t_mreset;
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    wrap_up;
  end
endmodule : test_module_sideband_control
